/* File: hdl/differential_channel_divider_regs.svh */
// Register indices, field positions, reset values and encodings of the divider channels.
`ifndef DIFFERENTIAL_CHANNEL_DIVIDER_REGS_SVH
`define DIFFERENTIAL_CHANNEL_DIVIDER_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_SECOND_COUNTS 10'h193
`define IDX_SECOND_CTRL 10'h194
`define IDX_SECOND_ROUTE 10'h195
`define IDX_THIRD_COUNTS 10'h196
`define IDX_THIRD_CTRL 10'h197
`define IDX_THIRD_ROUTE 10'h198
`define IDX_STATUS 10'h1F0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_COUNTS 8'h00
`define RST_SECOND_CTRL 8'h00
`define RST_THIRD_CTRL 8'h80
`define RST_ROUTE 8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CNT_LOW_MSB 7
`define CNT_LOW_LSB 4
`define CNT_HIGH_MSB 3
`define CNT_HIGH_LSB 0
`define CTL_BYPASS 7
`define CTL_IGNORE_SYNC 6
`define CTL_FORCE 5
`define CTL_START 4
`define CTL_PHASE_MSB 3
`define CTL_PHASE_LSB 0
`define ROUTE_DIRECT 1
`define ROUTE_DCC_OFF 0
`define ROUTE_MASK 8'h03

// ----------------------------------------------------------------------------
// Clock source select encodings
// ----------------------------------------------------------------------------
`define SRC_EXT 2'h0
`define SRC_DIV 2'h1
`define SRC_OSC 2'h2

`endif

/* File: hdl/divider_pkg.sv */
// Types shared by the divider channel files.
`default_nettype none
package divider_pkg;
  typedef logic [1:0] src_sel_t;
  typedef enum logic [1:0] {ST_HOLD, ST_PHASE, ST_LOW, ST_HIGH} div_state_t;
endpackage
`default_nettype wire

/* File: hdl/sync2.sv */
// Two-flop synchroniser for a group of pin levels.
`default_nettype none
module sync2 #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/rise_detect.sv */
// Rising-edge detector on an already synchronised level.
`default_nettype none
module rise_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  output logic rise
);
  logic prev_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;
endmodule
`default_nettype wire

/* File: hdl/differential_channel_divider.sv */
// Divider, sync, force and direct routing for the second and third differential pairs.
// Notes on behaviour
// - Output stays low for the low-count field plus one input cycles, so zero gives one, except where duty correction evens a one-cycle split.
// - Output stays high for the high-count field plus one input cycles, so zero gives one, except where duty correction evens a one-cycle split.
// - The bypass bit stops the divider and passes its input clock to the output.
// - With ignore-sync clear the divider follows the chip sync, with it set it does not.
// - The force bit sets the output level while sync is active, and software must set ignore-sync for it to act.
// - The start-level bit picks whether the output begins low or high.
// - A four-bit phase offset delays the first output level by that many input cycles.
// - Each channel's direct-route bit steers only its own output pair.
// - With direct-route clear the pair is fed from the channel's divider.
// - With direct-route set and source select 10b the oscillator drives the pair.
// - With direct-route set and source select 00b the external clock drives the pair.
// - With source select 01b the direct-route bit has no effect.
// - The duty-correction-disable bit turns duty correction on when zero, off when one.
`default_nettype none
`include "differential_channel_divider_regs.svh"
module differential_channel_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [11:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire divider_pkg::src_sel_t clock_source_select,
  input wire logic sync_active,
  input wire logic dist_clk_in,
  input wire logic osc_in,
  input wire logic ext_clk_in,
  output logic pair_two_output_a,
  output logic pair_two_output_b,
  output logic pair_three_output_a,
  output logic pair_three_output_b
);
  import divider_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [7:0] cnt_q [2];
  logic [7:0] cnt_d [2];
  logic [7:0] ctrl_q [2];
  logic [7:0] ctrl_d [2];
  logic [7:0] route_q [2];
  logic [7:0] route_d [2];
  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic hit;
  logic wr;
  logic [9:0] idx;
  logic [7:0] rd;

  div_state_t st_q [2];
  div_state_t st_d [2];
  logic [4:0] dcnt_q [2];
  logic [4:0] dcnt_d [2];
  logic lvl_q [2];
  logic lvl_d [2];

  logic [1:0] direct;
  logic [1:0] out_d;
  logic [1:0] out_q;
  logic [3:0] out_pins_q;

  logic [2:0] pins_s;
  logic dist_s;
  logic osc_s;
  logic ext_s;
  logic dist_rise;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Every clock pin is sampled, so the divider input rate must stay well below clk/2.
  sync2 #(
    .WIDTH(3)
  ) pin_sync (
    .clk(clk),
    .rst(rst),
    .d({ext_clk_in, osc_in, dist_clk_in}),
    .q(pins_s)
  );

  assign dist_s = pins_s[0];
  assign osc_s = pins_s[1];
  assign ext_s = pins_s[2];

  rise_detect dist_edge (
    .clk(clk),
    .rst(rst),
    .level(dist_s),
    .rise(dist_rise)
  );

  // --------------------------------------------------------------------------
  // Phase lengths
  // --------------------------------------------------------------------------
  function automatic logic [5:0] period_len(input logic [7:0] cnt);
    period_len = 6'({2'h0, cnt[`CNT_LOW_MSB:`CNT_LOW_LSB]})
      + 6'({2'h0, cnt[`CNT_HIGH_MSB:`CNT_HIGH_LSB]}) + 6'h02;
  endfunction

  // Duty correction only evens out a split that is already one cycle from balance;
  // whole-cycle counts cannot give half cycles, so the high phase takes the spare one.
  function automatic logic near_even(input logic [7:0] cnt);
    logic [3:0] lo;
    logic [3:0] hi;
    lo = cnt[`CNT_LOW_MSB:`CNT_LOW_LSB];
    hi = cnt[`CNT_HIGH_MSB:`CNT_HIGH_LSB];
    near_even = (lo == 4'(hi + 4'h1) && hi != 4'hF) || (hi == 4'(lo + 4'h1) && lo != 4'hF);
  endfunction

  function automatic logic [4:0] high_len(input logic [7:0] cnt, input logic dcc_on);
    logic [5:0] total;
    total = period_len(cnt);
    if (dcc_on && near_even(cnt)) begin
      high_len = 5'((total + 6'h01) >> 1);
    end else begin
      high_len = 5'({1'b0, cnt[`CNT_HIGH_MSB:`CNT_HIGH_LSB]}) + 5'h01;
    end
  endfunction

  function automatic logic [4:0] low_len(input logic [7:0] cnt, input logic dcc_on);
    low_len = 5'(period_len(cnt) - {1'b0, high_len(cnt, dcc_on)});
  endfunction

  // --------------------------------------------------------------------------
  // Wishbone slave and registers
  // --------------------------------------------------------------------------
  always_comb begin
    hit = wb_cyc && wb_stb && !ack_q;
    // Writes land at the edge at which the master sees ack, while it still holds the request.
    wr = wb_cyc && wb_stb && ack_q && wb_we && wb_sel[0];
    idx = wb_adr[11:2];
    cnt_d = cnt_q;
    ctrl_d = ctrl_q;
    route_d = route_q;
    rd = 8'h00;
    unique case (idx)
      `IDX_SECOND_COUNTS: begin
        rd = cnt_q[0];
        if (wr) cnt_d[0] = wb_dat_w[7:0];
      end
      `IDX_SECOND_CTRL: begin
        rd = ctrl_q[0];
        if (wr) ctrl_d[0] = wb_dat_w[7:0];
      end
      `IDX_SECOND_ROUTE: begin
        rd = route_q[0];
        if (wr) route_d[0] = wb_dat_w[7:0] & `ROUTE_MASK;
      end
      `IDX_THIRD_COUNTS: begin
        rd = cnt_q[1];
        if (wr) cnt_d[1] = wb_dat_w[7:0];
      end
      `IDX_THIRD_CTRL: begin
        rd = ctrl_q[1];
        if (wr) ctrl_d[1] = wb_dat_w[7:0];
      end
      `IDX_THIRD_ROUTE: begin
        rd = route_q[1];
        if (wr) route_d[1] = wb_dat_w[7:0] & `ROUTE_MASK;
      end
      `IDX_STATUS: begin
        rd = {4'h0, direct, out_q};
      end
      default: begin
        rd = 8'h00;
      end
    endcase
    ack_d = hit;
    dat_d = hit ? {24'h000000, rd} : dat_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q[0] <= `RST_COUNTS;
      cnt_q[1] <= `RST_COUNTS;
      ctrl_q[0] <= `RST_SECOND_CTRL;
      ctrl_q[1] <= `RST_THIRD_CTRL;
      route_q[0] <= `RST_ROUTE;
      route_q[1] <= `RST_ROUTE;
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      cnt_q <= cnt_d;
      ctrl_q <= ctrl_d;
      route_q <= route_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack = ack_q;
  assign wb_dat_r = dat_q;

  // --------------------------------------------------------------------------
  // Channel dividers
  // --------------------------------------------------------------------------
  // A bypassed divider is parked in the hold state, standing in for its power-down.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      logic obey;
      logic start_hi;
      logic dcc_on;
      logic [4:0] phase;
      obey = !ctrl_q[c][`CTL_IGNORE_SYNC];
      start_hi = ctrl_q[c][`CTL_START];
      dcc_on = !route_q[c][`ROUTE_DCC_OFF];
      phase = {1'b0, ctrl_q[c][`CTL_PHASE_MSB:`CTL_PHASE_LSB]};
      st_d[c] = st_q[c];
      dcnt_d[c] = dcnt_q[c];
      lvl_d[c] = lvl_q[c];
      if (ctrl_q[c][`CTL_BYPASS] || (obey && sync_active)) begin
        st_d[c] = ST_HOLD;
        dcnt_d[c] = 5'h00;
        lvl_d[c] = start_hi;
      end else if (st_q[c] == ST_HOLD) begin
        dcnt_d[c] = 5'h00;
        lvl_d[c] = start_hi;
        if (phase != 5'h00) begin
          st_d[c] = ST_PHASE;
        end else begin
          st_d[c] = start_hi ? ST_HIGH : ST_LOW;
        end
      end else if (dist_rise) begin
        unique case (st_q[c])
          ST_PHASE: begin
            if (dcnt_q[c] + 5'h01 == phase) begin
              st_d[c] = start_hi ? ST_HIGH : ST_LOW;
              dcnt_d[c] = 5'h00;
            end else begin
              dcnt_d[c] = dcnt_q[c] + 5'h01;
            end
          end
          ST_LOW: begin
            if (dcnt_q[c] + 5'h01 >= low_len(cnt_q[c], dcc_on)) begin
              st_d[c] = ST_HIGH;
              dcnt_d[c] = 5'h00;
              lvl_d[c] = 1'b1;
            end else begin
              dcnt_d[c] = dcnt_q[c] + 5'h01;
            end
          end
          ST_HIGH: begin
            if (dcnt_q[c] + 5'h01 >= high_len(cnt_q[c], dcc_on)) begin
              st_d[c] = ST_LOW;
              dcnt_d[c] = 5'h00;
              lvl_d[c] = 1'b0;
            end else begin
              dcnt_d[c] = dcnt_q[c] + 5'h01;
            end
          end
          ST_HOLD: begin
            st_d[c] = ST_HOLD;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        st_q[c] <= ST_HOLD;
        dcnt_q[c] <= 5'h00;
        lvl_q[c] <= 1'b0;
      end
    end else begin
      st_q <= st_d;
      dcnt_q <= dcnt_d;
      lvl_q <= lvl_d;
    end
  end

  // --------------------------------------------------------------------------
  // Output routing
  // --------------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // Each channel looks at its own route bit only.
      direct[c] = route_q[c][`ROUTE_DIRECT]
        && (clock_source_select == `SRC_OSC || clock_source_select == `SRC_EXT);
      if (direct[c]) begin
        out_d[c] = (clock_source_select == `SRC_OSC) ? osc_s : ext_s;
      end else if (ctrl_q[c][`CTL_BYPASS]) begin
        out_d[c] = dist_s;
      end else if (ctrl_q[c][`CTL_IGNORE_SYNC] && sync_active) begin
        out_d[c] = ctrl_q[c][`CTL_FORCE];
      end else begin
        out_d[c] = lvl_q[c];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_q <= 2'h0;
      out_pins_q <= 4'h0;
    end else begin
      out_q <= out_d;
      out_pins_q <= {out_d[1], out_d[1], out_d[0], out_d[0]};
    end
  end

  assign pair_two_output_a = out_pins_q[0];
  assign pair_two_output_b = out_pins_q[1];
  assign pair_three_output_a = out_pins_q[2];
  assign pair_three_output_b = out_pins_q[3];
endmodule
`default_nettype wire

/* File: dv/differential_channel_divider_chk.sv */
// Port-level assertions for the divider channel block.
`default_nettype none
`include "differential_channel_divider_regs.svh"
module differential_channel_divider_chk
  import divider_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [11:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  input wire logic [31:0] wb_dat_r,
  input wire logic wb_ack,
  input wire divider_pkg::src_sel_t clock_source_select,
  input wire logic sync_active,
  input wire logic dist_clk_in,
  input wire logic osc_in,
  input wire logic ext_clk_in,
  input wire logic pair_two_output_a,
  input wire logic pair_two_output_b,
  input wire logic pair_three_output_a,
  input wire logic pair_three_output_b
);
  // Shadow of the third channel's control and route, so levels can be tied to settings.
  logic [7:0] ctl_q, ctl_d, rt_q, rt_d;
  logic direct;
  always_comb begin
    ctl_d = ctl_q;
    rt_d = rt_q;
    direct = rt_q[1] && (clock_source_select == `SRC_EXT || clock_source_select == `SRC_OSC);
    if (wb_cyc && wb_stb && wb_ack && wb_we && wb_sel[0]) begin
      if (wb_adr[11:2] == `IDX_THIRD_CTRL) begin
        ctl_d = wb_dat_w[7:0];
      end
      if (wb_adr[11:2] == `IDX_THIRD_ROUTE) begin
        rt_d = wb_dat_w[7:0] & `ROUTE_MASK;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_q <= `RST_THIRD_CTRL;
      rt_q <= `RST_ROUTE;
    end else begin
      ctl_q <= ctl_d;
      rt_q <= rt_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req; wb_cyc && wb_stb && !wb_ack; endsequence
  sequence s_pulse; wb_ack ##1 !wb_ack; endsequence
  a_ack_next_cycle: assert property (s_req |=> s_pulse)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property ($rose(wb_ack) |-> $past(wb_cyc && wb_stb))
    else $error("ack without request");
  a_pair_two_same: assert property (pair_two_output_a == pair_two_output_b)
    else $error("second pair legs differ");
  a_pair_three_same: assert property (pair_three_output_a == pair_three_output_b)
    else $error("third pair legs differ");
  a_bypass_passes: assert property ((ctl_q[7] && !direct)[*6]
    |-> pair_three_output_a == $past(dist_clk_in, 3)) else $error("bypass not passing input");
  a_forced_level: assert property ((ctl_q[6] && sync_active && !ctl_q[7] && !direct
    && $stable(ctl_q))[*3] |-> pair_three_output_a == ctl_q[5]) else $error("forced level");
  a_sync_hold: assert property ((!ctl_q[6] && sync_active && !ctl_q[7] && !direct
    && $stable(ctl_q))[*4] |-> pair_three_output_a == ctl_q[4]) else $error("sync hold");
endmodule
bind differential_channel_divider differential_channel_divider_chk
  differential_channel_divider_chk_inst (.clk(clk), .rst(rst), .wb_cyc(wb_cyc),
  .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
  .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .clock_source_select(clock_source_select),
  .sync_active(sync_active), .dist_clk_in(dist_clk_in), .osc_in(osc_in),
  .ext_clk_in(ext_clk_in), .pair_two_output_a(pair_two_output_a),
  .pair_two_output_b(pair_two_output_b), .pair_three_output_a(pair_three_output_a),
  .pair_three_output_b(pair_three_output_b));
`default_nettype wire

/* File: dv/pair_sink.sv */
// Far-side model of one output pair: the length of each level seen by the receiver.
`default_nettype none
module pair_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic pair_a,
  input wire logic pair_b,
  output int hi_len,
  output int lo_len,
  output int edges,
  output int split_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  int run;
  logic last;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run <= 0;
      last <= 1'b0;
      hi_len <= 0;
      lo_len <= 0;
      edges <= 0;
    end else if (pair_a !== last) begin
      if (last) begin
        hi_len <= run;
      end else begin
        lo_len <= run;
      end
      edges <= edges + 1;
      run <= 1;
      last <= pair_a;
    end else begin
      run <= run + 1;
    end
  end
  // The receiver sees the pair as one signal, so every cycle with the legs apart is counted.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      split_cnt <= 0;
    end else if (pair_a !== pair_b) begin
      split_cnt <= split_cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* File: dv/differential_channel_divider_tb_top.sv */
// Self-checking bench for the divider channel block.
`default_nettype none
`include "differential_channel_divider_regs.svh"
module differential_channel_divider_tb_top import divider_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [11:0] wb_adr = 12'h000;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h00000000, wb_dat_r;
  src_sel_t clock_source_select = 2'h1;
  logic sync_active = 1'b0, dist_clk_in = 1'b0, osc_in = 1'b0, ext_clk_in = 1'b0;
  logic p2a, p2b, p3a, p3b;
  logic [2:0] dcnt;
  logic [7:0] tab [5];
  int error_cnt = 0, num_checks = 0, hi3, lo3, ed3, ta, tb, sp3;
  always #5 clk = ~clk;
  // The divider input runs at an eighth of the bus clock, inside the allowed rate.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dcnt <= 3'h0;
      dist_clk_in <= 1'b0;
    end else begin
      dcnt <= dcnt + 3'h1;
      dist_clk_in <= dcnt[2];
    end
  end
  differential_channel_divider differential_channel_divider_inst (.clk(clk), .rst(rst),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .clock_source_select(clock_source_select), .sync_active(sync_active),
    .dist_clk_in(dist_clk_in), .osc_in(osc_in), .ext_clk_in(ext_clk_in),
    .pair_two_output_a(p2a), .pair_two_output_b(p2b), .pair_three_output_a(p3a),
    .pair_three_output_b(p3b));
  pair_sink pair_sink_inst (.clk(clk), .rst(rst), .pair_a(p3a), .pair_b(p3b),
    .hi_len(hi3), .lo_len(lo3), .edges(ed3), .split_cnt(sp3));
  // ---------------------------------------------------------------------------
  // Access and comparison tasks
  // ---------------------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      results();
    end
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [9:0] idx, input logic we, input logic [7:0] d,
                      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'h0};
    wb_sel <= 4'hF;
    wb_dat_w <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    r = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    give_up(n, 20);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    xfer(idx, 1'b1, d, r);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    logic [31:0] r;
    xfer(idx, 1'b0, 8'h00, r);
    check(r, {24'h000000, e});
  endtask
  task automatic wait_edges(input int k);
    int n, e;
    n = 0;
    e = ed3;
    while (ed3 < e + k && n < 3000) begin
      @(posedge clk);
      n++;
    end
    give_up(n, 3000);
  endtask
  // Releases sync at a fixed point of the input clock so two runs line up.
  task automatic first_rise(input logic [7:0] ctl, output int t);
    int n;
    wr(`IDX_THIRD_CTRL, ctl);
    repeat (8) @(posedge clk);
    n = 0;
    while (dcnt !== 3'h0 && n < 8) begin
      @(posedge clk);
      n++;
    end
    sync_active <= 1'b0;
    t = 0;
    while (p3a !== 1'b1 && t < 500) begin
      @(posedge clk);
      t++;
    end
    give_up(t, 500);
    sync_active <= 1'b1;
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(`IDX_SECOND_COUNTS + 10'(i), i == 4 ? 8'h80 : 8'h00);
    end
    rd(10'h100, 8'h00);
    wr(`IDX_SECOND_ROUTE, 8'hFF);
    rd(`IDX_SECOND_ROUTE, 8'h03);
    wr(`IDX_SECOND_ROUTE, 8'h00);
    $display("test registers done");
    wr(`IDX_THIRD_ROUTE, 8'h01);
    wr(`IDX_THIRD_CTRL, 8'h00);
    tab = '{8'h00, 8'h21, 8'hFF, 8'h0F, 8'h32};
    for (int i = 0; i < 5; i++) begin
      wr(`IDX_THIRD_COUNTS, tab[i]);
      wait_edges(4);
      check(hi3, (int'(tab[i][3:0]) + 1) * 8);
      check(lo3, (int'(tab[i][7:4]) + 1) * 8);
    end
    wr(`IDX_THIRD_ROUTE, 8'h00);
    wr(`IDX_THIRD_COUNTS, 8'h21);
    wait_edges(4);
    check(hi3, 24);
    check(lo3, 16);
    wr(`IDX_THIRD_CTRL, 8'h80);
    wait_edges(4);
    check(hi3, 4);
    check(lo3, 4);
    $display("test divide ratio done");
    sync_active <= 1'b1;
    tab = '{8'h00, 8'h10, 8'h60, 8'h40, 8'h50};
    for (int i = 0; i < 5; i++) begin
      wr(`IDX_THIRD_CTRL, tab[i]);
      repeat (8) @(posedge clk);
      check(p3a, 32'(i == 1 || i == 2));
      check(p2a, 0);
    end
    $display("test sync and force done");
    wr(`IDX_THIRD_ROUTE, 8'h02);
    for (int s = 0; s < 4; s++) begin
      for (int v = 0; v < 2; v++) begin
        clock_source_select <= 2'(s);
        osc_in <= 1'(v);
        ext_clk_in <= 1'(1 - v);
        repeat (8) @(posedge clk);
        check(p3a, s == 2 ? v : (s == 0 ? 1 - v : 0));
        check(p2a, 0);
        if (s == 2 && v == 1) begin
          rd(`IDX_STATUS, 8'h0A);
        end
      end
    end
    wr(`IDX_THIRD_ROUTE, 8'h00);
    clock_source_select <= 2'h2;
    repeat (8) @(posedge clk);
    check(p3a, 0);
    $display("test direct route done");
    clock_source_select <= 2'h1;
    wr(`IDX_THIRD_COUNTS, 8'h00);
    first_rise(8'h00, ta);
    first_rise(8'h03, tb);
    check(tb - ta, 24);
    $display("test phase offset done");
    check(sp3, 0);
    results();
  end
endmodule
`default_nettype wire
